// File: margin_check_regs.svh
// constants for the margin check controller: word fields, codes, timing
`ifndef MARGIN_CHECK_REGS_SVH
`define MARGIN_CHECK_REGS_SVH
// control word bit positions, word is bits [35:0], bit 35 = left sign
`define MC_WORD_W 36
`define MC_TYPE_POS 35
`define MC_ARST_LSB 33
`define MC_RRST_LSB 31
`define MC_DUR_LSB 29
`define MC_POL_POS 28
`define MC_HINT_POS 27
`define MC_MAG_LSB 23
`define MC_VGRP_LSB 20
`define MC_EQ_LSB 16
`define MC_CGRP_LSB 6
`define MC_LINE_LSB 0
// codes
`define MC_EQ_SIMPLEX 4'h9
`define MC_DUR_INF 2'h0
`define MC_DUR_3S 2'h1
`define MC_DUR_7S 2'h2
// restart addresses and load word count
`define MC_ADDR_ZERO 17'h00000
`define MC_ADDR_TEST 17'h1FFF0
`define MC_LOAD_WORDS 6'h18
// times
`define MC_CLK_NS 10
`define MC_T3_MS 3000
`define MC_T7_MS 7000
`define MC_T30_MS 30000
`define MC_CLR_MS 400
`endif

// File: margin_check_pkg.sv
// types shared by the margin check controller
package margin_check_pkg;
    typedef enum logic [1:0] {
        RST_DRUM = 2'b00,
        RST_ZERO = 2'b01,
        RST_TEST = 2'b10,
        RST_CARD = 2'b11
    } restart_e;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_APPLIED = 3'b001,
        ST_CLEAR_WAIT = 3'b010,
        ST_CLEAR = 3'b011,
        ST_LOAD = 3'b100,
        ST_GO = 3'b101
    } state_e;
endpackage

// File: magnitude_rom.sv
// magnitude code to volts table with registered output
`timescale 1ns/1ns
module magnitude_rom (
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    input wire logic [3:0] i_code,
    output logic [6:0] o_volts
);
    logic [6:0] volts_d;
    // monotonic level table
    always_comb begin
        case (i_code)
            4'h0: volts_d = 7'h00;
            4'h1: volts_d = 7'h0A;
            4'h2: volts_d = 7'h0C;
            4'h3: volts_d = 7'h0E;
            4'h4: volts_d = 7'h10;
            4'h5: volts_d = 7'h12;
            4'h6: volts_d = 7'h14;
            4'h7: volts_d = 7'h19;
            4'h8: volts_d = 7'h1E;
            4'h9: volts_d = 7'h23;
            4'hA: volts_d = 7'h28;
            4'hB: volts_d = 7'h32;
            4'hC: volts_d = 7'h3C;
            4'hD: volts_d = 7'h46;
            4'hE: volts_d = 7'h55;
            default: volts_d = 7'h64;
        endcase
    end
    // registered read
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_volts <= 7'h00;
        end else begin
            o_volts <= volts_d;
        end
    end
endmodule // magnitude_rom

// File: margin_check_controller.sv
// margin check controller: decodes control words, times excursions, sequences restarts
`timescale 1ns/1ns
`include "margin_check_regs.svh"
// How it works
// - sign bit one marks a start word with full new selection.
// - start word drops old selection, latches new; equipment 1001 means simplex.
// - sign bit zero is a change word altering magnitude, polarity, applied restart only.
// - change word restarts duration timer from zero, keeping old duration.
// - change word is ignored unless an excursion is still applied.
// - duration field picks infinite, 3 s, 7 s or 30 s.
// - timer expiry removes excursion, clears control, runs removal restart.
// - apply zeroes all duration timers before selecting one.
// - polarity zero is positive, one is negative.
// - magnitude code maps to sixteen rising levels, 0 V to 100 V.
// - applied magnitude never exceeds the selected line's safe limit.
// - safe limit hint bit is ignored.
// - duplex and simplex removals each clear control before removal restart.
// - control clear resets all computing and control flip-flops.
// - apply sets duplex or simplex sense flag; removals clear their flag.
// - sense branches fire only when flag set and leave it alone.
// - two independent restart fields for applied and removed, four modes.
// - drum restart copies 30 octal words to core zero, continues at zero.
// - test restart sets program counter to first test memory location.
// - card restart loads one card of 30 octal words, continues at zero.
// - apply to control clear delay lies in 300 to 500 ms.
// - apply takes live register word and removes any applied excursion.
module margin_check_controller #(
    // ms to cycles, worked in 64 bits so the long durations do not overflow
    parameter int unsigned CLR_CYC = 32'((64'(`MC_CLR_MS) * 64'hF4240) / 64'(`MC_CLK_NS)),
    parameter int unsigned T3_CYC = 32'((64'(`MC_T3_MS) * 64'hF4240) / 64'(`MC_CLK_NS)),
    parameter int unsigned T7_CYC = 32'((64'(`MC_T7_MS) * 64'hF4240) / 64'(`MC_CLK_NS)),
    parameter int unsigned T30_CYC = 32'((64'(`MC_T30_MS) * 64'hF4240) / 64'(`MC_CLK_NS))
) (
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    input wire logic [35:0] i_live_word,
    input wire logic i_apply,
    input wire logic i_remove_duplex,
    input wire logic i_remove_simplex,
    input wire logic i_sense_duplex,
    input wire logic i_sense_simplex,
    input wire logic [6:0] i_safe_limit,
    input wire logic i_load_ack,
    output logic o_branch,
    output logic o_duplex_flag,
    output logic o_simplex_flag,
    output logic o_excursion_on,
    output logic o_polarity_neg,
    output logic [6:0] o_volts,
    output logic [2:0] o_voltage_group,
    output logic [3:0] o_equipment_group,
    output logic [5:0] o_circuit_groups,
    output logic [5:0] o_lines,
    output logic o_control_clear,
    output logic o_load_req,
    output logic o_load_card,
    output logic [16:0] o_load_addr,
    output logic o_pc_load,
    output logic [16:0] o_pc_value
);
    typedef struct packed {
        margin_check_pkg::state_e st;
        logic removing;
        logic [31:0] dur_cnt;
        logic [31:0] clr_cnt;
        logic [1:0] arst;
        logic [1:0] rrst;
        logic [1:0] dur;
        logic pol;
        logic [3:0] mag;
        logic [2:0] vgrp;
        logic [3:0] eq;
        logic [5:0] cgrp;
        logic [5:0] line;
        logic on;
        logic dflag;
        logic sflag;
        logic branch;
        logic cclr;
        logic load_req;
        logic load_card;
        logic [5:0] load_idx;
        logic pc_load;
        logic [16:0] pc_val;
    } state_s;

    state_s s_q;
    state_s s_d;
    logic [6:0] table_volts;
    logic [31:0] dur_limit;
    margin_check_pkg::restart_e mode;

    // duration code to cycle count
    function automatic logic [31:0] dur_cycles(input logic [1:0] code);
        case (code)
            `MC_DUR_3S: dur_cycles = 32'(T3_CYC);
            `MC_DUR_7S: dur_cycles = 32'(T7_CYC);
            default: dur_cycles = 32'(T30_CYC);
        endcase
    endfunction

    magnitude_rom u_rom (
        .i_sys_clk(i_sys_clk),
        .i_arst_n(i_arst_n),
        .i_code(s_q.mag),
        .o_volts(table_volts)
    );

    assign dur_limit = dur_cycles(s_q.dur);
    assign mode = margin_check_pkg::restart_e'(s_q.removing ? s_q.rrst : s_q.arst);

    // next-state logic
    always_comb begin
        s_d = s_q;
        s_d.branch = 1'b0;
        s_d.cclr = 1'b0;
        s_d.pc_load = 1'b0;
        // sense branches read flags only
        s_d.branch = (i_sense_duplex & s_q.dflag) | (i_sense_simplex & s_q.sflag);
        // running duration timer while applied
        if (s_q.on && s_q.dur != `MC_DUR_INF) begin
            s_d.dur_cnt = s_q.dur_cnt + 32'h1;
        end
        case (s_q.st)
            margin_check_pkg::ST_IDLE, margin_check_pkg::ST_APPLIED: begin
                if (i_apply) begin
                    if (i_live_word[`MC_TYPE_POS]) begin
                        // start word: drop old, latch new
                        s_d.on = 1'b1;
                        s_d.arst = i_live_word[`MC_ARST_LSB +: 2];
                        s_d.rrst = i_live_word[`MC_RRST_LSB +: 2];
                        s_d.dur = i_live_word[`MC_DUR_LSB +: 2];
                        s_d.pol = i_live_word[`MC_POL_POS];
                        s_d.mag = i_live_word[`MC_MAG_LSB +: 4]; // hint bit unused
                        s_d.vgrp = i_live_word[`MC_VGRP_LSB +: 3];
                        s_d.eq = i_live_word[`MC_EQ_LSB +: 4];
                        s_d.cgrp = i_live_word[`MC_CGRP_LSB +: 6];
                        s_d.line = i_live_word[`MC_LINE_LSB +: 6];
                        s_d.dur_cnt = 32'h0;
                        s_d.removing = 1'b0;
                        s_d.clr_cnt = 32'h0;
                        s_d.st = margin_check_pkg::ST_CLEAR_WAIT;
                        if (i_live_word[`MC_EQ_LSB +: 4] == `MC_EQ_SIMPLEX) begin
                            s_d.sflag = 1'b1;
                            s_d.dflag = 1'b0; // old duplex excursion dropped
                        end else begin
                            s_d.dflag = 1'b1;
                            s_d.sflag = 1'b0; // old simplex excursion dropped
                        end
                    end else if (s_q.on) begin
                        // change word: keep selection and duration
                        s_d.arst = i_live_word[`MC_ARST_LSB +: 2];
                        s_d.pol = i_live_word[`MC_POL_POS];
                        s_d.mag = i_live_word[`MC_MAG_LSB +: 4];
                        s_d.dur_cnt = 32'h0;
                        s_d.removing = 1'b0;
                        s_d.clr_cnt = 32'h0;
                        s_d.st = margin_check_pkg::ST_CLEAR_WAIT;
                    end
                end else if (i_remove_duplex || i_remove_simplex) begin
                    // removal instruction
                    s_d.on = 1'b0;
                    s_d.removing = 1'b1;
                    s_d.clr_cnt = 32'h0;
                    s_d.st = margin_check_pkg::ST_CLEAR_WAIT;
                    if (i_remove_duplex) begin
                        s_d.dflag = 1'b0;
                    end
                    if (i_remove_simplex) begin
                        s_d.sflag = 1'b0;
                    end
                end else if (s_q.on && s_q.dur != `MC_DUR_INF && s_q.dur_cnt >= dur_limit) begin
                    // timer expiry removes excursion
                    s_d.on = 1'b0;
                    s_d.removing = 1'b1;
                    s_d.dflag = 1'b0;
                    s_d.sflag = 1'b0;
                    s_d.st = margin_check_pkg::ST_CLEAR;
                end
            end
            margin_check_pkg::ST_CLEAR_WAIT: begin
                s_d.clr_cnt = s_q.clr_cnt + 32'h1;
                if (s_q.clr_cnt >= 32'(CLR_CYC) - 32'h1) begin
                    s_d.st = margin_check_pkg::ST_CLEAR;
                end
            end
            margin_check_pkg::ST_CLEAR: begin
                s_d.cclr = 1'b1;
                s_d.load_idx = 6'h00;
                if (mode == margin_check_pkg::RST_DRUM || mode == margin_check_pkg::RST_CARD) begin
                    s_d.load_req = 1'b1;
                    s_d.load_card = (mode == margin_check_pkg::RST_CARD);
                    s_d.st = margin_check_pkg::ST_LOAD;
                end else begin
                    s_d.st = margin_check_pkg::ST_GO;
                end
            end
            margin_check_pkg::ST_LOAD: begin
                // one word per acknowledge into core 0..27 octal
                if (i_load_ack) begin
                    s_d.load_idx = s_q.load_idx + 6'h01;
                    if (s_q.load_idx == `MC_LOAD_WORDS - 6'h01) begin
                        s_d.load_req = 1'b0;
                        s_d.load_card = 1'b0;
                        s_d.st = margin_check_pkg::ST_GO;
                    end
                end
            end
            default: begin
                s_d.pc_load = 1'b1;
                s_d.pc_val = (mode == margin_check_pkg::RST_TEST) ? `MC_ADDR_TEST : `MC_ADDR_ZERO;
                s_d.st = s_q.on ? margin_check_pkg::ST_APPLIED : margin_check_pkg::ST_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // output registers; magnitude clamped to safe limit
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_volts <= 7'h00;
            o_branch <= 1'b0;
            o_duplex_flag <= 1'b0;
            o_simplex_flag <= 1'b0;
            o_excursion_on <= 1'b0;
            o_polarity_neg <= 1'b0;
            o_voltage_group <= 3'h0;
            o_equipment_group <= 4'h0;
            o_circuit_groups <= 6'h00;
            o_lines <= 6'h00;
            o_control_clear <= 1'b0;
            o_load_req <= 1'b0;
            o_load_card <= 1'b0;
            o_load_addr <= 17'h00000;
            o_pc_load <= 1'b0;
            o_pc_value <= 17'h00000;
        end else begin
            o_volts <= !s_q.on ? 7'h00 : (table_volts > i_safe_limit ? i_safe_limit : table_volts);
            o_branch <= s_q.branch;
            o_duplex_flag <= s_q.dflag;
            o_simplex_flag <= s_q.sflag;
            o_excursion_on <= s_q.on;
            o_polarity_neg <= s_q.pol;
            o_voltage_group <= s_q.vgrp;
            o_equipment_group <= s_q.eq;
            o_circuit_groups <= s_q.cgrp;
            o_lines <= s_q.line;
            o_control_clear <= s_q.cclr;
            o_load_req <= s_d.load_req; // in step with the acks counted in s_q
            o_load_card <= s_d.load_card;
            o_load_addr <= {11'h000, s_d.load_idx}; // index of the word now offered
            o_pc_load <= s_q.pc_load;
            o_pc_value <= s_q.pc_val;
        end
    end

    // assertions
    chk_flag_on_apply: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        (s_q.st == margin_check_pkg::ST_IDLE && i_apply && i_live_word[35] && !i_live_word[19])
        |=> s_q.dflag) else $error("duplex flag not set on apply");
    chk_change_ignored: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        (s_q.st == margin_check_pkg::ST_IDLE && !s_q.on && i_apply && !i_live_word[35]
         && !i_remove_duplex && !i_remove_simplex)
        |=> s_q.st == margin_check_pkg::ST_IDLE) else $error("change word acted while off");
    chk_branch_sense: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        (i_sense_simplex && s_q.sflag) |=> ##1 o_branch) else $error("branch missed");
    chk_clamp_limit: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        ##1 (o_volts <= $past(i_safe_limit))) else $error("magnitude above safe limit");
    chk_clear_then_pc: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        (s_q.st == margin_check_pkg::ST_CLEAR && mode == margin_check_pkg::RST_TEST)
        |=> ##1 (s_q.pc_load && s_q.pc_val == 17'h1FFF0)) else $error("test restart address");
    chk_remove_clears: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        ((s_q.st == margin_check_pkg::ST_IDLE || s_q.st == margin_check_pkg::ST_APPLIED)
         && !i_apply && i_remove_duplex)
        |=> (!s_q.dflag && s_q.st == margin_check_pkg::ST_CLEAR_WAIT)) else $error("removal");
    chk_timer_zero: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        (s_q.st == margin_check_pkg::ST_APPLIED && i_apply && i_live_word[35])
        |=> s_q.dur_cnt == 32'h0) else $error("timer not zeroed");
    chk_expiry_clear: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        (s_q.st == margin_check_pkg::ST_APPLIED && !i_apply && !i_remove_duplex
         && !i_remove_simplex && s_q.dur != 2'h0 && s_q.dur_cnt >= dur_limit)
        |=> ##1 s_q.cclr) else $error("expiry without clear");
    // a simplex start word while duplex is applied swaps the sense flags
    chk_start_flag_swap: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        (s_q.st == margin_check_pkg::ST_APPLIED && i_apply && i_live_word[`MC_TYPE_POS]
         && i_live_word[`MC_EQ_LSB +: 4] == `MC_EQ_SIMPLEX)
        |=> (s_q.sflag && !s_q.dflag)) else $error("start word kept old flag");
    // one restart word moves per acknowledge while loading
    sequence load_word_taken;
        s_q.st == margin_check_pkg::ST_LOAD && i_load_ack;
    endsequence
    sequence load_index_advanced;
        s_q.load_idx == $past(s_q.load_idx) + 6'h01;
    endsequence
    chk_load_index_step: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        load_word_taken |=> load_index_advanced) else $error("load index did not advance");
    // control clear is a single-cycle pulse
    chk_clear_pulse_once: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        o_control_clear |=> !o_control_clear) else $error("control clear held too long");
endmodule // margin_check_controller

// File: restart_loader.sv
// partner model: acknowledges restart load words and checks their order
`timescale 1ns/1ns
module restart_loader (
    input wire logic i_sys_clk,
    input wire logic i_slow,
    input wire logic i_clear,
    input wire logic i_load_req,
    input wire logic [16:0] i_load_addr,
    output logic o_ack,
    output int o_words,
    output int o_addr_bad
);
    logic phase = 1'b0;
    initial begin
        o_ack = 1'b0;
        o_words = 0;
        o_addr_bad = 0;
    end
    // one word moves at each edge where request and acknowledge are both high
    always @(posedge i_sys_clk) begin
        if (i_clear === 1'b1) begin
            o_words = 0;
            o_addr_bad = 0;
        end
        if (i_load_req === 1'b1 && o_ack === 1'b1) begin
            if (i_load_addr !== 17'(o_words)) o_addr_bad = o_addr_bad + 1;
            o_words = o_words + 1;
        end
        phase = ~phase;
        // a slow partner answers every other cycle, never past one block
        o_ack <= (i_load_req === 1'b1) && (o_words < 24) && (!i_slow || phase);
    end
endmodule // restart_loader

// File: margin_check_controller_test.sv
// self-checking bench for the margin check controller
`timescale 1ns/1ns
module margin_check_controller_test;
    localparam int CLR = 20;
    localparam int T3 = 50;
    localparam int T7 = 100;
    localparam int T30 = 200;
    logic i_sys_clk, i_arst_n, i_apply, i_remove_duplex, i_remove_simplex;
    logic i_sense_duplex, i_sense_simplex, i_load_ack, slow;
    logic [35:0] i_live_word;
    logic [6:0] i_safe_limit, o_volts;
    logic o_branch, o_duplex_flag, o_simplex_flag, o_excursion_on, o_polarity_neg;
    logic [2:0] o_voltage_group;
    logic [3:0] o_equipment_group;
    logic [5:0] o_circuit_groups, o_lines;
    logic o_control_clear, o_load_req, o_load_card, o_pc_load;
    logic [16:0] o_load_addr, o_pc_value;
    int n_fail = 0, num_checks = 0, words, addr_bad, dly, br, cyc = 0, t0;
    logic [6:0] vt [16] = '{7'h00, 7'h0A, 7'h0C, 7'h0E, 7'h10, 7'h12, 7'h14, 7'h19,
                            7'h1E, 7'h23, 7'h28, 7'h32, 7'h3C, 7'h46, 7'h55, 7'h64};

    margin_check_controller #(.CLR_CYC(CLR), .T3_CYC(T3), .T7_CYC(T7), .T30_CYC(T30))
        margin_check_controller_i (.i_sys_clk, .i_arst_n, .i_live_word, .i_apply,
        .i_remove_duplex, .i_remove_simplex, .i_sense_duplex, .i_sense_simplex,
        .i_safe_limit, .i_load_ack, .o_branch, .o_duplex_flag, .o_simplex_flag,
        .o_excursion_on, .o_polarity_neg, .o_volts, .o_voltage_group, .o_equipment_group,
        .o_circuit_groups, .o_lines, .o_control_clear, .o_load_req, .o_load_card,
        .o_load_addr, .o_pc_load, .o_pc_value);
    restart_loader restart_loader_i (.i_sys_clk, .i_slow(slow), .i_clear(o_control_clear),
        .i_load_req(o_load_req), .i_load_addr(o_load_addr), .o_ack(i_load_ack),
        .o_words(words), .o_addr_bad(addr_bad));

    // clock and cycle count
    initial begin
        i_sys_clk = 1'b0;
        forever #5 i_sys_clk = ~i_sys_clk;
    end
    always @(posedge i_sys_clk) cyc <= cyc + 1;

    task automatic check(input string nm, input logic [35:0] seen, input logic [35:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // every drive lands 1 ns after a rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask
    function automatic logic [35:0] mk(input logic st, input logic [1:0] ar, rr, dur,
        input logic pol, hint, input logic [3:0] mag, input logic [2:0] vg,
        input logic [3:0] eq, input logic [5:0] cg, ln);
        return {st, ar, rr, dur, pol, hint, mag, vg, eq, 4'h0, cg, ln};
    endfunction
    // one-cycle instruction: 0 apply, 1/2 removals, 3/4 sense branches
    task automatic pulse(input int k);
        case (k)
            0: i_apply = 1'b1;
            1: i_remove_duplex = 1'b1;
            2: i_remove_simplex = 1'b1;
            3: i_sense_duplex = 1'b1;
            default: i_sense_simplex = 1'b1;
        endcase
        tick(1);
        {i_apply, i_remove_duplex, i_remove_simplex, i_sense_duplex, i_sense_simplex} = 5'h00;
    endtask
    task automatic await_clear(input int lim);
        dly = 0;
        while (o_control_clear !== 1'b1 && dly < lim) begin
            tick(1);
            dly++;
        end
    endtask
    // follow the restart that comes after a control clear, mode m
    task automatic finish(input int m);
        int n;
        logic card;
        n = 0;
        card = 1'b0;
        while (o_pc_load !== 1'b1 && n < 300) begin
            if (o_load_req === 1'b1) card = o_load_card;
            tick(1);
            n++;
        end
        check("restart seen", o_pc_load, 1'b1);
        check("restart pc", o_pc_value, (m == 2) ? 17'h1FFF0 : 17'h00000);
        check("load words", words, (m == 0 || m == 3) ? 24 : 0);
        check("card load", card, m == 3);
        check("load addr order", addr_bad, 0);
        tick(2);
    endtask
    task automatic run(input int k, input int m);
        pulse(k);
        await_clear(1000); // program halts until the restart
        check("clear delay", dly >= CLR - 2 && dly <= CLR + 4, 1'b1);
        finish(m);
    endtask
    task automatic sense(input int k, input int exp);
        pulse(k);
        br = 0;
        repeat (4) begin
            br += (o_branch === 1'b1);
            tick(1);
        end
        check("branch", br, exp);
    endtask

    // watchdog on the whole run
    initial begin
        tick(20000);
        n_fail++;
        wrap_up;
    end

    initial begin
        {i_apply, i_remove_duplex, i_remove_simplex, i_sense_duplex, i_sense_simplex} = 5'h00;
        i_arst_n = 1'b0;
        i_live_word = 36'h0;
        i_safe_limit = 7'h64;
        slow = 1'b0;
        tick(3);
        i_arst_n = 1'b1;
        tick(1);
        check("reset excursion", o_excursion_on, 1'b0);
        check("reset flags", {o_duplex_flag, o_simplex_flag}, 2'h0);
        // duplex start words through every applied-restart mode
        for (int m = 0; m < 4; m++) begin
            slow = m[0];
            i_live_word = mk(1'b1, m[1:0], 2'h1, 2'h0, m[0], 1'b0, 4'(15 - m), 3'(m + 1),
                             4'(m + 1), 6'h20 >> m, 6'h01 << m);
            run(0, m);
            check("groups", {o_voltage_group, o_equipment_group, o_circuit_groups, o_lines},
                  {3'(m + 1), 4'(m + 1), 6'h20 >> m, 6'h01 << m});
            check("volts", o_volts, vt[15 - m]);
            check("polarity", o_polarity_neg, m[0]);
            check("flags", {o_excursion_on, o_duplex_flag, o_simplex_flag}, 3'h6);
        end
        // change words walk the whole magnitude table, selections kept
        for (int c = 0; c < 16; c++) begin
            i_live_word = mk(1'b0, 2'h1, 2'h0, 2'h0, 1'b0, 1'b0, 4'(c), 3'h0, 4'h0, 6'h00, 6'h00);
            run(0, 1);
            check("change volts", o_volts, vt[c]);
            check("kept sel", {o_equipment_group, o_lines}, {4'h4, 6'h08});
        end
        // simplex start with hint bit set, then clamp to a 25 V line
        i_live_word = mk(1'b1, 2'h1, 2'h2, 2'h0, 1'b0, 1'b1, 4'hF, 3'h2, 4'h9, 6'h04, 6'h02);
        run(0, 1);
        check("hint ignored", o_volts, 7'h64);
        check("simplex flags", {o_duplex_flag, o_simplex_flag, o_circuit_groups}, 8'h44);
        i_safe_limit = 7'h19;
        i_live_word = mk(1'b0, 2'h1, 2'h0, 2'h0, 1'b0, 1'b0, 4'hF, 3'h0, 4'h0, 6'h00, 6'h00);
        run(0, 1);
        check("clamp", o_volts, 7'h19);
        i_safe_limit = 7'h64;
        sense(4, 1);
        sense(3, 0);
        check("flag kept", o_simplex_flag, 1'b1);
        run(2, 2);
        check("removed", {o_excursion_on, o_simplex_flag, o_volts}, 9'h000);
        sense(4, 0);
        pulse(0);
        await_clear(CLR + 10);
        check("change ignored", {dly, o_excursion_on}, {CLR + 10, 1'b0});
        // infinite duration, then duplex removal with a slow card restart
        i_live_word = mk(1'b1, 2'h1, 2'h3, 2'h0, 1'b1, 1'b0, 4'h5, 3'h3, 4'h2, 6'h01, 6'h20);
        run(0, 1);
        await_clear(300);
        check("infinite", {dly, o_excursion_on}, {300, 1'b1});
        slow = 1'b1;
        run(1, 3); // never right after the simplex removal
        check("dup removed", {o_excursion_on, o_duplex_flag}, 2'h0);
        // a change word restarts the 7 s timer from zero
        i_live_word = mk(1'b1, 2'h1, 2'h1, 2'h2, 1'b0, 1'b0, 4'h3, 3'h1, 4'h1, 6'h01, 6'h01);
        run(0, 1);
        tick(30);
        i_live_word = mk(1'b0, 2'h1, 2'h0, 2'h0, 1'b0, 1'b0, 4'h4, 3'h0, 4'h0, 6'h00, 6'h00);
        t0 = cyc;
        run(0, 1);
        await_clear(400);
        check("retimed", cyc - t0 >= T7 && cyc - t0 <= T7 + CLR + 40, 1'b1);
        finish(1);
        // each timed duration expires in its own window
        for (int d = 1; d < 4; d++) begin
            i_live_word = mk(1'b1, 2'h1, 2'h2, 2'(d), 1'b0, 1'b0, 4'h2, 3'h1, 4'h3, 6'h02, 6'h04);
            t0 = cyc;
            run(0, 1);
            await_clear(400);
            check("expiry", (cyc - t0) >= (d == 1 ? T3 : d == 2 ? T7 : T30) &&
                  (cyc - t0) <= (d == 1 ? T3 : d == 2 ? T7 : T30) + CLR + 40, 1'b1);
            finish(2);
            check("expired", {o_excursion_on, o_duplex_flag}, 2'h0);
        end
        wrap_up;
    end
endmodule // margin_check_controller_test
